// ### aux_io_defines.svh
`ifndef AUX_IO_DEFINES_SVH
`define AUX_IO_DEFINES_SVH

// Register word addresses on the Avalon-MM slave.
`define ADDR_CTRL       4'h0
`define ADDR_SRC_SEL    4'h1
`define ADDR_PARAM_BASE 4'h2
`define ADDR_PARAM_LAST 4'h8
`define ADDR_STATUS     4'h9
`define ADDR_AIN01      4'hA
`define ADDR_AIN23      4'hB

// Field positions.
`define CTRL_GAS_CAL_BIT 0
`define PARAM_VALID_BIT  31
`define AIN_HI_LSB       16
`define STATUS_START_BIT 4

// Parameter slots, index = word address minus the base.
`define P_HR    3'd0
`define P_CO2   3'd1
`define P_AGENT 3'd2
`define P_PLOW  3'd3
`define P_PHIGH 3'd4
`define P_SPO2  3'd5
`define P_RR    3'd6
`define P_COUNT 7

// Timing, in the units printed, and the clock rate.
`define CLK_MHZ          125
`define US_PER_MS        1000
`define DEFIB_PULSE_MS   10
`define PACE_PULSE_US    1000
`define REFRESH_MS       10
`define TEST1_BASE_MS    1000
`define TEST2_BASE_MS    4000
`define GAS_PERIOD_MS    4000
`define STARTUP_TRIANGLES 3

// Voltage levels in millivolts and the output code scale.
`define MV_MIN      (-5000)
`define MV_MAX      5000
`define MV_SPAN     10000
`define MV_GAS_CAL  2000
`define MV_TRI1_PK  5000
`define CODE_MAX    4095
`define AGENT_MAX   100
`endif

// ### aux_io_pkg.sv
package aux_io_pkg;
   typedef enum logic [3:0] {
      SRC_OFF, SRC_HR, SRC_CO2, SRC_AGENT, SRC_PLOW, SRC_PHIGH,
      SRC_SPO2_40, SRC_SPO2_60, SRC_SPO2_80, SRC_RR,
      SRC_TEST1, SRC_TEST2, SRC_NEG5, SRC_ZERO, SRC_POS5
   } src_sel_t;

   typedef enum {AIN_IDLE, AIN_WAIT} ain_state_t;

   typedef struct packed {
      logic [2:0] chan;
      logic [11:0] code;
   } dac_word_t;

   typedef struct packed {
      logic [1:0] chan;
      logic [9:0] code;
   } adc_word_t;
endpackage

// ### aux_io_signal_generator.sv
//
// Contract
// - Defib sync output pulses high 10 ms.
// - Defib events ignored while pulse is high.
// - Nurse call held until alarm clears/mute.
// - Pacemaker sync pulse 0.5 to 2.5 ms.
// - Four digital bits: defib, nurse, pace, reserved.
// - Four analog inputs sampled every 10 ms.
// - Analog input samples are 10-bit codes.
// - Eight analog outputs, 12-bit codes each.
// - Every analog output refreshed every 10 ms.
// - Output codes span -5 V to +5 V linearly.
// - Sources reset to off; off drives nothing.
// - Selection change written to non-volatile store.
// - Invalid source keeps the last valid value.
// - Heart rate 0-300 maps to 0-3 V.
// - CO2/agent saturate at 10%, map 0-5 V.
// - Low-res pressure -20..320 to -0.2..3.2 V.
// - High-res pressure -20..50 to -2..5 V.
// - Saturation windows map onto -5..+5 V.
// - Breath rate 0-150 maps to 0-1.5 V.
// - Test one: 1 s triangle 0 to 5 V.
// - Test two: 4 s triangle -5 to +5 V.
// - Steady test levels -5, 0, +5 V.
// - Start-up emits three 1 s triangles.
// - Gas calibration: 0.25 Hz 0/2 V square.
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`include "aux_io_defines.svh"

module aux_io_signal_generator
   import aux_io_pkg::*;
#(
   parameter int MS_CYCLES = `US_PER_MS * `CLK_MHZ,
   parameter int DEFIB_CYCLES = `DEFIB_PULSE_MS * `US_PER_MS * `CLK_MHZ,
   parameter int PACE_CYCLES = `PACE_PULSE_US * `CLK_MHZ
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic defib_evt,
   input wire logic pace_evt,
   input wire logic alarm_red,
   input wire logic alarm_yellow,
   input wire logic alarm_white,
   input wire logic alarm_mute_key,
   output logic [3:0] dig_out,
   output logic adc_start,
   output logic [1:0] adc_chan,
   input wire logic adc_done,
   input wire logic [9:0] adc_code,
   output logic dac_load,
   output dac_word_t dac_word,
   output logic [7:0] dac_on,
   output logic nv_wr,
   output logic [31:0] nv_data
);

   logic wait_done_ff;
   logic [31:0] readdata_ff;
   logic [31:0] ctrl_ff;
   logic [31:0] src_sel_ff;
   logic [31:0] param_ff [0:`P_COUNT-1];
   logic [9:0] ain_ff [0:3];
   logic nv_wr_ff;
   logic [31:0] nv_data_ff;
   logic defib_ff;
   logic [31:0] defib_cnt_ff;
   logic pace_ff;
   logic [31:0] pace_cnt_ff;
   logic nurse_ff;
   logic mute_s1_ff, mute_s2_ff, mute_s3_ff, mute_stable_ff;
   logic [31:0] ms_cnt_ff;
   logic ms_tick;
   logic [3:0] ref_cnt_ff;
   logic refresh_tick;
   logic [11:0] t1_ms_ff;
   logic [11:0] t4_ms_ff;
   logic [11:0] start_ms_ff;
   logic startup_ff;
   ain_state_t ain_state_ff;
   logic [1:0] ain_idx_ff;
   logic adc_start_ff;
   logic dac_busy_ff;
   logic [2:0] dac_idx_ff;
   logic [11:0] hold_ff [0:7];
   logic dac_load_ff;
   dac_word_t dac_word_ff;
   logic [7:0] dac_on_ff;
   logic bus_req;
   logic bus_take;
   logic alarm_any;
   logic mute_press;
   src_sel_t cur_sel;
   int cur_mv;
   logic cur_valid;
   logic [11:0] cur_code;

   // Round to the nearest of the 4096 levels after clamping the voltage.
   function automatic logic [11:0] mv_to_code(input int mv);
      int m;
      m = mv;
      if (m < `MV_MIN) begin
         m = `MV_MIN;
      end
      if (m > `MV_MAX) begin
         m = `MV_MAX;
      end
      return 12'(((m - `MV_MIN) * `CODE_MAX + `MV_SPAN / 2) / `MV_SPAN);
   endfunction

   function automatic int pval(input logic [2:0] idx);
      return int'(signed'(param_ff[idx][15:0]));
   endfunction

   // One wait state gives the registered read data time to settle.
   assign bus_req = avs_read | avs_write;
   assign avs_waitrequest = bus_req & ~wait_done_ff;
   assign bus_take = bus_req & wait_done_ff;
   assign avs_readdata = readdata_ff;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wait_done_ff <= 1'b0;
      end else begin
         wait_done_ff <= bus_req & ~wait_done_ff;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         readdata_ff <= 32'h0000_0000;
      end else if (avs_read & ~wait_done_ff) begin
         readdata_ff <= 32'h0000_0000;
         if (avs_address == `ADDR_CTRL) begin
            readdata_ff <= ctrl_ff;
         end else if (avs_address == `ADDR_SRC_SEL) begin
            readdata_ff <= src_sel_ff;
         end else if (avs_address >= `ADDR_PARAM_BASE && avs_address <= `ADDR_PARAM_LAST) begin
            readdata_ff <= param_ff[3'(avs_address - `ADDR_PARAM_BASE)];
         end else if (avs_address == `ADDR_STATUS) begin
            readdata_ff <= {27'h0000000, startup_ff, dig_out};
         end else if (avs_address == `ADDR_AIN01) begin
            readdata_ff <= {6'h00, ain_ff[1], 6'h00, ain_ff[0]};
         end else if (avs_address == `ADDR_AIN23) begin
            readdata_ff <= {6'h00, ain_ff[3], 6'h00, ain_ff[2]};
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_ff <= 32'h0000_0000;
         for (int i = 0; i < `P_COUNT; i++) begin
            param_ff[i] <= 32'h0000_0000;
         end
      end else if (bus_take & avs_write) begin
         if (avs_address == `ADDR_CTRL) begin
            ctrl_ff <= {31'h00000000, avs_writedata[`CTRL_GAS_CAL_BIT]};
         end else if (avs_address >= `ADDR_PARAM_BASE && avs_address <= `ADDR_PARAM_LAST) begin
            param_ff[3'(avs_address - `ADDR_PARAM_BASE)] <= avs_writedata;
         end
      end
   end

   // Selection lives in one word so the whole set is saved in one store write.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         src_sel_ff <= 32'h0000_0000;
         nv_wr_ff <= 1'b0;
         nv_data_ff <= 32'h0000_0000;
      end else begin
         nv_wr_ff <= 1'b0;
         if (bus_take & avs_write & (avs_address == `ADDR_SRC_SEL)) begin
            src_sel_ff <= avs_writedata;
            if (avs_writedata != src_sel_ff) begin
               nv_wr_ff <= 1'b1;
               nv_data_ff <= avs_writedata;
            end
         end
      end
   end
   assign nv_wr = nv_wr_ff;
   assign nv_data = nv_data_ff;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         defib_ff <= 1'b0;
         defib_cnt_ff <= 32'h0000_0000;
      end else if (defib_ff) begin
         if (defib_cnt_ff == 32'(DEFIB_CYCLES - 1)) begin
            defib_ff <= 1'b0;
         end
         defib_cnt_ff <= defib_cnt_ff + 32'h0000_0001;
      end else if (defib_evt) begin
         defib_ff <= 1'b1;
         defib_cnt_ff <= 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pace_ff <= 1'b0;
         pace_cnt_ff <= 32'h0000_0000;
      end else if (pace_ff) begin
         if (pace_cnt_ff == 32'(PACE_CYCLES - 1)) begin
            pace_ff <= 1'b0;
         end
         pace_cnt_ff <= pace_cnt_ff + 32'h0000_0001;
      end else if (pace_evt) begin
         pace_ff <= 1'b1;
         pace_cnt_ff <= 32'h0000_0000;
      end
   end

   // The key is a panel pin; the third stage filters single-cycle glitches.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mute_s1_ff <= 1'b0;
         mute_s2_ff <= 1'b0;
         mute_s3_ff <= 1'b0;
         mute_stable_ff <= 1'b0;
      end else begin
         mute_s1_ff <= alarm_mute_key;
         mute_s2_ff <= mute_s1_ff;
         mute_s3_ff <= mute_s2_ff;
         if (mute_s2_ff == mute_s3_ff) begin
            mute_stable_ff <= mute_s3_ff;
         end
      end
   end
   assign mute_press = (mute_s2_ff == mute_s3_ff) & mute_s3_ff & ~mute_stable_ff;
   assign alarm_any = alarm_red | alarm_yellow | alarm_white;

   logic alarm_prev_ff;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         nurse_ff <= 1'b0;
         alarm_prev_ff <= 1'b0;
      end else begin
         alarm_prev_ff <= alarm_any;
         if (alarm_any & ~alarm_prev_ff) begin
            nurse_ff <= 1'b1;
         end else if (~alarm_any | mute_press) begin
            nurse_ff <= 1'b0;
         end
      end
   end

   assign dig_out = {1'b0, pace_ff, nurse_ff, defib_ff};

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ms_cnt_ff <= 32'h0000_0000;
         ref_cnt_ff <= 4'h0;
      end else begin
         if (ms_tick) begin
            ms_cnt_ff <= 32'h0000_0000;
            ref_cnt_ff <= (ref_cnt_ff == 4'(`REFRESH_MS - 1)) ? 4'h0 : ref_cnt_ff + 4'h1;
         end else begin
            ms_cnt_ff <= ms_cnt_ff + 32'h0000_0001;
         end
      end
   end
   assign ms_tick = (ms_cnt_ff == 32'(MS_CYCLES - 1));
   assign refresh_tick = ms_tick & (ref_cnt_ff == 4'(`REFRESH_MS - 1));

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         t1_ms_ff <= 12'h000;
         t4_ms_ff <= 12'h000;
         start_ms_ff <= 12'h000;
         startup_ff <= 1'b1;
      end else if (ms_tick) begin
         t1_ms_ff <= (t1_ms_ff == 12'(`TEST1_BASE_MS - 1)) ? 12'h000 : t1_ms_ff + 12'h001;
         t4_ms_ff <= (t4_ms_ff == 12'(`TEST2_BASE_MS - 1)) ? 12'h000 : t4_ms_ff + 12'h001;
         if (startup_ff) begin
            start_ms_ff <= start_ms_ff + 12'h001;
            if (start_ms_ff == 12'(`STARTUP_TRIANGLES * `TEST1_BASE_MS - 1)) begin
               startup_ff <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ain_state_ff <= AIN_IDLE;
         ain_idx_ff <= 2'h0;
         adc_start_ff <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            ain_ff[i] <= 10'h000;
         end
      end else begin
         adc_start_ff <= 1'b0;
         case (ain_state_ff)
            AIN_IDLE: begin
               if (refresh_tick) begin
                  adc_start_ff <= 1'b1;
                  ain_idx_ff <= 2'h0;
                  ain_state_ff <= AIN_WAIT;
               end
            end
            AIN_WAIT: begin
               if (adc_done) begin
                  ain_ff[ain_idx_ff] <= adc_code;
                  ain_idx_ff <= ain_idx_ff + 2'h1;
                  if (ain_idx_ff == 2'h3) begin
                     ain_state_ff <= AIN_IDLE;
                  end else begin
                     adc_start_ff <= 1'b1;
                  end
               end
            end
            default: begin
               ain_state_ff <= AIN_IDLE;
            end
         endcase
      end
   end
   assign adc_start = adc_start_ff;
   assign adc_chan = ain_idx_ff;

   // One output channel is evaluated per cycle, so one scaler serves all eight.
   always_comb begin
      int t;
      int sat;
      t = 0;
      sat = 0;
      cur_sel = src_sel_t'(src_sel_ff[4 * dac_idx_ff +: 4]);
      cur_mv = 0;
      cur_valid = 1'b1;
      case (cur_sel)
         SRC_HR: begin
            cur_mv = pval(`P_HR) * 10;
            cur_valid = param_ff[`P_HR][`PARAM_VALID_BIT];
         end
         SRC_CO2, SRC_AGENT: begin
            sat = (cur_sel == SRC_CO2) ? pval(`P_CO2) : pval(`P_AGENT);
            if (sat > `AGENT_MAX) begin
               sat = `AGENT_MAX;
            end
            cur_mv = sat * 50;
            cur_valid = param_ff[(cur_sel == SRC_CO2) ? `P_CO2 : `P_AGENT][`PARAM_VALID_BIT];
            if (ctrl_ff[`CTRL_GAS_CAL_BIT]) begin
               cur_mv = (int'(t4_ms_ff) < `GAS_PERIOD_MS / 2) ? `MV_GAS_CAL : 0;
               cur_valid = 1'b1;
            end
         end
         SRC_PLOW: begin
            cur_mv = pval(`P_PLOW) * 10;
            cur_valid = param_ff[`P_PLOW][`PARAM_VALID_BIT];
         end
         SRC_PHIGH: begin
            cur_mv = pval(`P_PHIGH) * 100;
            cur_valid = param_ff[`P_PHIGH][`PARAM_VALID_BIT];
         end
         SRC_SPO2_40, SRC_SPO2_60, SRC_SPO2_80: begin
            sat = (cur_sel == SRC_SPO2_40) ? 40 : (cur_sel == SRC_SPO2_60) ? 60 : 80;
            cur_mv = `MV_MIN + (pval(`P_SPO2) - sat) * `MV_SPAN / (100 - sat);
            cur_valid = param_ff[`P_SPO2][`PARAM_VALID_BIT];
         end
         SRC_RR: begin
            cur_mv = pval(`P_RR) * 10;
            cur_valid = param_ff[`P_RR][`PARAM_VALID_BIT];
         end
         SRC_TEST1: begin
            t = int'(t1_ms_ff);
            cur_mv = (t < `TEST1_BASE_MS / 2) ? t * 10 : (`TEST1_BASE_MS - t) * 10;
         end
         SRC_TEST2: begin
            t = int'(t4_ms_ff);
            cur_mv = (t < `TEST2_BASE_MS / 2) ? `MV_MIN + t * 5 : `MV_MAX - (t - `TEST2_BASE_MS / 2) * 5;
         end
         SRC_NEG5: begin
            cur_mv = `MV_MIN;
         end
         SRC_ZERO: begin
            cur_mv = 0;
         end
         SRC_POS5: begin
            cur_mv = `MV_MAX;
         end
         default: begin
            cur_mv = 0;
         end
      endcase
      if (startup_ff) begin
         t = int'(t1_ms_ff);
         cur_mv = (t < `TEST1_BASE_MS / 2) ? t * 10 : (`TEST1_BASE_MS - t) * 10;
         cur_valid = 1'b1;
      end
      cur_code = cur_valid ? mv_to_code(cur_mv) : hold_ff[dac_idx_ff];
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dac_busy_ff <= 1'b0;
         dac_idx_ff <= 3'h0;
         dac_load_ff <= 1'b0;
         dac_word_ff <= '0;
         dac_on_ff <= 8'h00;
         for (int i = 0; i < 8; i++) begin
            hold_ff[i] <= 12'h800;
         end
      end else begin
         dac_load_ff <= 1'b0;
         if (dac_busy_ff) begin
            hold_ff[dac_idx_ff] <= cur_code;
            dac_word_ff <= '{chan: dac_idx_ff, code: cur_code};
            dac_load_ff <= 1'b1;
            dac_on_ff[dac_idx_ff] <= (cur_sel != SRC_OFF);
            dac_idx_ff <= dac_idx_ff + 3'h1;
            if (dac_idx_ff == 3'h7) begin
               dac_busy_ff <= 1'b0;
            end
         end else if (refresh_tick) begin
            dac_busy_ff <= 1'b1;
            dac_idx_ff <= 3'h0;
         end
      end
   end
   assign dac_load = dac_load_ff;
   assign dac_word = dac_word_ff;
   assign dac_on = dac_on_ff;

endmodule

// ### aux_io_signal_generator_properties.sv
`timescale 1ns/1ps
`include "aux_io_defines.svh"
module aux_io_checker
   import aux_io_pkg::*;
#(
   parameter int MS_CYCLES = 20,
   parameter int DEFIB_CYCLES = 50,
   parameter int PACE_CYCLES = 10
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_waitrequest,
   input wire logic defib_evt,
   input wire logic alarm_red,
   input wire logic alarm_yellow,
   input wire logic alarm_white,
   input wire logic [3:0] dig_out,
   input wire logic adc_start,
   input wire logic [1:0] adc_chan,
   input wire logic adc_done,
   input wire logic dac_load,
   input wire dac_word_t dac_word,
   input wire logic nv_wr,
   input wire logic [31:0] nv_data
);
   localparam int PERIOD = `REFRESH_MS * MS_CYCLES;
   int defib_len_ff;
   int pace_len_ff;
   int gap_ff;
   logic seen_ff;
   // Pulse widths are counted here because a repetition count may not be a parameter.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) defib_len_ff <= 0;
      else defib_len_ff <= dig_out[0] ? defib_len_ff + 1 : 0;
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) pace_len_ff <= 0;
      else pace_len_ff <= dig_out[2] ? pace_len_ff + 1 : 0;
   end
   // The first burst after reset has no predecessor, so its gap is not judged.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         gap_ff <= 0;
         seen_ff <= 1'b0;
      end else if ($rose(dac_load)) begin
         gap_ff <= 1;
         seen_ff <= 1'b1;
      end else begin
         gap_ff <= gap_ff + 1;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_head;
      dac_load && dac_word.chan == 3'h0;
   endsequence
   sequence s_tail;
      dac_load [*7] ##1 !dac_load;
   endsequence
   AST_DAC_BURST: assert property ($rose(dac_load) |-> s_head ##1 s_tail)
      else $error("refresh burst is not eight words");
   AST_DAC_CHAN: assert property (dac_load && $past(dac_load)
      |-> dac_word.chan == $past(dac_word.chan) + 3'h1)
      else $error("refresh channel order broken");
   AST_DAC_PERIOD: assert property ($rose(dac_load) && seen_ff |-> gap_ff == PERIOD)
      else $error("refresh period wrong");
   AST_DEFIB_START: assert property (defib_evt && !dig_out[0] |=> dig_out[0])
      else $error("defib sync did not start");
   AST_DEFIB_WIDTH: assert property ($fell(dig_out[0])
      |-> defib_len_ff == `DEFIB_PULSE_MS * MS_CYCLES)
      else $error("defib sync width wrong");
   AST_DEFIB_CAUSE: assert property ($rose(dig_out[0]) |-> $past(defib_evt))
      else $error("defib sync without event");
   AST_PACE_WIDTH: assert property ($fell(dig_out[2])
      |-> pace_len_ff * 2 >= MS_CYCLES && pace_len_ff * 2 <= 5 * MS_CYCLES)
      else $error("pace sync width wrong");
   AST_NURSE_SET: assert property ($rose(alarm_red || alarm_yellow || alarm_white)
      |-> ##[1:2] dig_out[1])
      else $error("nurse call not set");
   AST_NURSE_CLEAR: assert property (!(alarm_red || alarm_yellow || alarm_white) [*2] |-> !dig_out[1])
      else $error("nurse call not cleared");
   AST_RESERVED: assert property (dig_out[3] == 1'b0)
      else $error("reserved output driven");
   AST_NV_CAUSE: assert property (nv_wr |-> nv_data == $past(avs_writedata)
      && $past(avs_write && !avs_waitrequest && avs_address == `ADDR_SRC_SEL))
      else $error("store write without selection write");
   AST_ADC_NEXT: assert property (adc_done && adc_chan != 2'h3 |-> ##[1:2] adc_start)
      else $error("next conversion not started");
endmodule
bind aux_io_signal_generator aux_io_checker #(.MS_CYCLES(MS_CYCLES), .DEFIB_CYCLES(DEFIB_CYCLES),
   .PACE_CYCLES(PACE_CYCLES)) i_aux_io_checker (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
   .defib_evt(defib_evt), .alarm_red(alarm_red), .alarm_yellow(alarm_yellow), .alarm_white(alarm_white),
   .dig_out(dig_out), .adc_start(adc_start), .adc_chan(adc_chan), .adc_done(adc_done), .dac_load(dac_load),
   .dac_word(dac_word), .nv_wr(nv_wr), .nv_data(nv_data));

// ### aux_adc_model.sv
`timescale 1ns/1ps
module aux_adc_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic adc_start,
   input wire logic [1:0] adc_chan,
   input wire logic slow,
   input wire logic [39:0] ain_vals,
   output logic adc_done,
   output logic [9:0] adc_code
);
   int wait_ff;
   logic [1:0] chan_ff;
   // Between results the code lines toggle, so a stale code is never mistaken for a fresh one.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wait_ff <= 0;
         chan_ff <= 2'h0;
         adc_done <= 1'b0;
         adc_code <= 10'h0;
      end else begin
         adc_done <= 1'b0;
         adc_code <= ~adc_code;
         if (adc_start) begin
            wait_ff <= slow ? 9 : 1;
            chan_ff <= adc_chan;
         end else if (wait_ff == 1) begin
            adc_done <= 1'b1;
            adc_code <= ain_vals[chan_ff * 10 +: 10];
            wait_ff <= 0;
         end else if (wait_ff > 1) begin
            wait_ff <= wait_ff - 1;
         end
      end
   end
endmodule

// ### tb_aux_io_signal_generator.sv
`timescale 1ns/1ps
`include "aux_io_defines.svh"
module tb_aux_io_signal_generator
   import aux_io_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic defib_evt = 1'b0;
   logic pace_evt = 1'b0;
   logic [2:0] alm = 3'h0;
   logic alarm_mute_key = 1'b0;
   logic [3:0] dig_out;
   logic adc_start;
   logic [1:0] adc_chan;
   logic adc_done;
   logic [9:0] adc_code;
   logic dac_load;
   dac_word_t dac_word;
   logic [7:0] dac_on;
   logic nv_wr;
   logic [31:0] nv_data;
   logic slow = 1'b0;
   logic [39:0] ain_vals;
   logic [31:0] rng = 32'h0001_44DF;
   logic [31:0] rd_q[$];
   dac_word_t dac_q[$];
   logic [11:0] exp_code[8];
   int err_total = 0;
   int checks = 0;
   int nv_cnt = 0;
   int defib_cnt = 0;
   int pace_cnt = 0;
   always #4 clk_sys = ~clk_sys;
   aux_io_signal_generator #(.MS_CYCLES(20), .DEFIB_CYCLES(200), .PACE_CYCLES(20)) i_aux_io_signal_generator (
      .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .defib_evt(defib_evt), .pace_evt(pace_evt), .alarm_red(alm[0]), .alarm_yellow(alm[1]),
      .alarm_white(alm[2]), .alarm_mute_key(alarm_mute_key), .dig_out(dig_out), .adc_start(adc_start),
      .adc_chan(adc_chan), .adc_done(adc_done), .adc_code(adc_code), .dac_load(dac_load),
      .dac_word(dac_word), .dac_on(dac_on), .nv_wr(nv_wr), .nv_data(nv_data));
   aux_adc_model i_aux_adc_model (.clk_sys(clk_sys), .rst(rst), .adc_start(adc_start), .adc_chan(adc_chan),
      .slow(slow), .ain_vals(ain_vals), .adc_done(adc_done), .adc_code(adc_code));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   // Ties round upward; a tie lies equally near both codes, so either is nearest.
   function automatic logic [11:0] code_of(input int mv);
      int c;
      c = (mv < -5000) ? 0 : ((mv + 5000) * 4095 + 5000) / 10000;
      if (c > 4095) c = 4095;
      return c[11:0];
   endfunction
   task report_and_stop;
      $display("errors %0d checks %0d", err_total, checks);
      if (err_total == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task fail(input string m);
      err_total++;
      $display("[ERR] %0t %s", $time, m);
   endtask
   task chk(input logic ok, input string m);
      checks++;
      if (ok !== 1'b1) fail(m);
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task bus(input logic [3:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      avs_address <= a;
      avs_read <= !w;
      avs_write <= w;
      avs_writedata <= d;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
         if (n > 20) begin
            fail("bus timeout");
            report_and_stop();
         end
      end while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      bus(a, 1'b0, 32'h0);
   endtask
   task push_dac;
      for (int i = 0; i < 8; i++) dac_q.push_back({i[2:0], exp_code[i]});
   endtask
   always @(posedge clk_sys) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && rd_q.size() > 0) begin
         checks++;
         if (avs_readdata !== rd_q[0]) fail("read data mismatch");
         void'(rd_q.pop_front());
      end
      if (dac_load === 1'b1 && dac_q.size() > 0 && dac_word.chan === dac_q[0].chan) begin
         checks++;
         if (dac_word !== dac_q[0]) fail("output code mismatch");
         void'(dac_q.pop_front());
      end
      if (nv_wr === 1'b1) nv_cnt++;
      if ($rose(dig_out[0])) defib_cnt++;
      if ($rose(dig_out[2])) pace_cnt++;
   end
   initial begin
      repeat (100000) @(posedge clk_sys);
      fail("run timeout");
      report_and_stop();
   end
   initial begin
      logic [31:0] sel;
      int hr;
      int rr;
      rng = xs(rng);
      ain_vals = {rng[7:0], xs(rng)};
      tick(3);
      rst <= 1'b0;
      rd(`ADDR_STATUS, 32'h10);
      rd(`ADDR_SRC_SEL, 32'h0);
      chk(dac_on === 8'h00, "outputs enabled after reset");
      rd(4'hF, 32'h0);
      sel = {SRC_SPO2_40, SRC_PHIGH, SRC_PLOW, SRC_CO2, SRC_RR, SRC_POS5, SRC_NEG5, SRC_HR};
      bus(`ADDR_SRC_SEL, 1'b1, sel);
      bus(`ADDR_SRC_SEL, 1'b1, sel);
      tick(2);
      chk(nv_cnt == 1, "store write count");
      rd(`ADDR_SRC_SEL, sel);
      defib_evt <= 1'b1;
      tick(1);
      defib_evt <= 1'b0;
      rd(`ADDR_STATUS, 32'h11);
      defib_evt <= 1'b1;
      tick(1);
      defib_evt <= 1'b0;
      tick(210);
      pace_evt <= 1'b1;
      tick(5);
      pace_evt <= 1'b0;
      rd(`ADDR_STATUS, 32'h14);
      tick(20);
      chk(defib_cnt == 1 && pace_cnt == 1, "sync pulse count");
      for (int i = 0; i < 3; i++) begin
         alm <= 3'h1 << i;
         tick(4);
         rd(`ADDR_STATUS, 32'h12);
         if (i == 2) begin
            alarm_mute_key <= 1'b1;
            tick(10);
            alarm_mute_key <= 1'b0;
         end else begin
            alm <= 3'h0;
         end
         tick(4);
         rd(`ADDR_STATUS, 32'h10);
         alm <= 3'h0;
         tick(4);
      end
      rng = xs(rng);
      hr = rng % 301;
      rr = (rng >> 9) % 151;
      bus(`ADDR_PARAM_BASE + `P_HR, 1'b1, {16'h8000, 16'(hr)});
      bus(`ADDR_PARAM_BASE + `P_CO2, 1'b1, 32'h8000_0096);
      bus(`ADDR_PARAM_BASE + `P_PLOW, 1'b1, 32'h8000_0140);
      bus(`ADDR_PARAM_BASE + `P_PHIGH, 1'b1, 32'h8000_000F);
      bus(`ADDR_PARAM_BASE + `P_SPO2, 1'b1, 32'h8000_0055);
      bus(`ADDR_PARAM_BASE + `P_RR, 1'b1, {16'h8000, 16'(rr)});
      exp_code = '{code_of(hr * 10), 12'h000, 12'hFFF, code_of(rr * 10), code_of(5000), code_of(3200),
         code_of(1500), code_of(2500)};
      tick(60400);
      rd(`ADDR_STATUS, 32'h0);
      push_dac();
      tick(450);
      chk(dac_q.size() == 0, "refresh not seen");
      chk(dac_on === 8'hFF, "outputs not enabled");
      bus(`ADDR_PARAM_BASE + `P_HR, 1'b1, 32'h0000_012C);
      push_dac();
      tick(450);
      chk(dac_q.size() == 0, "held value not seen");
      bus(`ADDR_CTRL, 1'b1, 32'h0000_0001);
      rd(`ADDR_CTRL, 32'h0000_0001);
      exp_code[4] = code_of(0);
      push_dac();
      tick(450);
      chk(dac_q.size() == 0, "calibration level not seen");
      slow <= 1'b1;
      tick(450);
      rd(`ADDR_AIN01, {6'h0, ain_vals[19:10], 6'h0, ain_vals[9:0]});
      rd(`ADDR_AIN23, {6'h0, ain_vals[39:30], 6'h0, ain_vals[29:20]});
      tick(4);
      chk(rd_q.size() == 0, "reads unanswered");
      report_and_stop();
   end
endmodule
